/* File: verilog/predriver_supply_regs.svh */
// register offsets, fields, reset values and timing counts
// assumes a 200 MHz system clock
`ifndef PREDRIVER_SUPPLY_REGS_SVH
`define PREDRIVER_SUPPLY_REGS_SVH

// printed offsets are register indices; byte address is four times the index
`define CONFIG_INDEX 12'h1C5
`define STATUS_INDEX 12'h1D2
`define IRQ_STATUS_INDEX 12'h1E0
`define IRQ_MASK_INDEX 12'h1E1
`define CONFIG_ADDR 14'h0714
`define STATUS_ADDR 14'h0748
`define IRQ_STATUS_ADDR 14'h0780
`define IRQ_MASK_ADDR 14'h0784

// driver_configuration fields
`define CFG_EXT_SUPPLY_BIT 0
`define CFG_RAIL_IRQ_EN_BIT 1
`define CFG_LOGIC_IRQ_EN_BIT 2
`define CFG_RESET 16'h0001

// driver_supply_status fields
`define STS_RAIL_UV_BIT 0
`define STS_LOGIC_UV_BIT 1
`define STS_DRIVERS_OFF_BIT 2
`define STS_REG_ON_BIT 3
`define STS_RAIL_NOW_BIT 4

// event bits for irq status and mask
`define EVT_RAIL_UV 0
`define EVT_LOGIC_UV 1
`define EVT_RECOVER 2
`define EVT_COUNT 3
`define MASK_RESET 3'h0

// recovery filter, typical 1.3 us, in nanoseconds
`define FILTER_TIME_NS 1300
`define CLOCK_PERIOD_NS 5
`define FILTER_CYCLES (`FILTER_TIME_NS / `CLOCK_PERIOD_NS)

`endif

/* File: verilog/predriver_supply_pkg.sv */
// types shared by the supply control block
// assumes the register header is included by the user files
package predriver_supply_pkg;

  typedef enum logic [1:0] {
    rail_down_type_e = 2'b00,
    rail_filter_type_e = 2'b01,
    rail_up_type_e = 2'b10
  } rail_state_type;

  typedef struct packed {
    logic rail_undervoltage;
    logic logic_supply_undervoltage;
    logic battery_lockout_clear;
    logic power_on_reset_n;
    logic external_reset_pin_n;
  } supply_inputs_type;

  typedef struct packed {
    logic regulator_enable;
    logic regulator_off_request;
    logic drivers_enable;
  } supply_outputs_type;

endpackage

/* File: verilog/rail_recovery_filter.sv */
// anti-glitch recovery filter for the pre-driver rail
// assumes a synchronous comparator input
`include "predriver_supply_regs.svh"
module rail_recovery_filter
  import predriver_supply_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clock_enable,
  // comparator and result
  input wire logic rail_undervoltage,
  output logic rail_good
);

  rail_state_type state;
  logic [8:0] count;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= rail_down_type_e;
      count <= 9'h000;
      rail_good <= 1'b0;
    end else if (clock_enable) begin
      unique case (state)
        rail_down_type_e: begin
          count <= 9'h000;
          rail_good <= 1'b0;
          if (!rail_undervoltage) begin
            state <= rail_filter_type_e;
          end
        end
        rail_filter_type_e: begin
          if (rail_undervoltage) begin
            state <= rail_down_type_e;
            count <= 9'h000;
          end else if (count == 9'(`FILTER_CYCLES - 1)) begin
            state <= rail_up_type_e;
            rail_good <= 1'b1;
          end else begin
            count <= count + 9'h001;
          end
        end
        rail_up_type_e: begin
          if (rail_undervoltage) begin
            state <= rail_down_type_e;
            rail_good <= 1'b0;
          end
        end
        default: begin
          state <= rail_down_type_e;
          rail_good <= 1'b0;
        end
      endcase
    end
  end

endmodule // rail_recovery_filter

/* File: verilog/event_capture.sv */
// sticky event flags, write-one-to-clear, set wins over clear
// assumes events are single-cycle pulses or levels
`include "predriver_supply_regs.svh"
module event_capture
  import predriver_supply_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clock_enable,
  // events and clears
  input wire logic [`EVT_COUNT-1:0] event_set,
  input wire logic [`EVT_COUNT-1:0] event_clear,
  output logic [`EVT_COUNT-1:0] event_flag
);

  genvar i;
  generate
    for (i = 0; i < `EVT_COUNT; i = i + 1) begin : g_flag
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          event_flag[i] <= 1'b0;
        end else if (clock_enable) begin
          if (event_set[i]) begin
            event_flag[i] <= 1'b1;
          end else if (event_clear[i]) begin
            event_flag[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

endmodule // event_capture

/* File: verilog/predriver_supply_control.sv */
// pre-driver supply control: regulator gating, rail supervision, registers
// assumes synchronous comparator and pin inputs, AXI4-Lite master outside
//
// Implementation choice: the AXI4-Lite slave port.
`include "predriver_supply_regs.svh"
module predriver_supply_control
  import predriver_supply_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clock_enable,
  // supply monitors and pins
  input wire supply_inputs_type supply_in,
  // regulator and driver controls
  output supply_outputs_type supply_out,
  output logic host_interrupt_n,
  // axi write address
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi read address
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  logic [15:0] config_reg;
  logic [`EVT_COUNT-1:0] irq_mask;
  logic [`EVT_COUNT-1:0] event_flag;
  logic [`EVT_COUNT-1:0] event_set;
  logic [`EVT_COUNT-1:0] event_clear;
  logic [13:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic rail_good;
  logic rail_uv_last;
  logic logic_uv_last;
  logic drivers_last;
  logic rail_flag;
  logic logic_flag;
  logic regulator_on;
  logic drivers_on;
  logic write_go;
  logic read_go;
  logic status_read;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic write_ok;

  // recovery filter
  rail_recovery_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_enable(clock_enable),
    .rail_undervoltage(supply_in.rail_undervoltage),
    .rail_good(rail_good)
  );

  // regulator gating
  always_comb begin
    regulator_on = supply_in.power_on_reset_n
      && supply_in.battery_lockout_clear
      && !supply_in.logic_supply_undervoltage
      && supply_in.external_reset_pin_n
      && !config_reg[`CFG_EXT_SUPPLY_BIT]
      && aresetn;
  end

  // driver enable, same path for internal or external rail
  always_comb begin
    drivers_on = rail_good
      && !supply_in.rail_undervoltage
      && !supply_in.logic_supply_undervoltage;
  end

  always_comb begin
    supply_out.regulator_enable = regulator_on;
    supply_out.regulator_off_request = config_reg[`CFG_EXT_SUPPLY_BIT];
    supply_out.drivers_enable = drivers_on;
  end

  // edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail_uv_last <= 1'b0;
      logic_uv_last <= 1'b0;
      drivers_last <= 1'b0;
    end else if (clock_enable) begin
      rail_uv_last <= supply_in.rail_undervoltage;
      logic_uv_last <= supply_in.logic_supply_undervoltage;
      drivers_last <= drivers_on;
    end
  end

  // status flags, set wins, cleared by reading status
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rail_flag <= 1'b0;
      logic_flag <= 1'b0;
    end else if (clock_enable) begin
      if (supply_in.rail_undervoltage) begin
        rail_flag <= 1'b1;
      end else if (status_read) begin
        rail_flag <= 1'b0;
      end
      if (supply_in.logic_supply_undervoltage) begin
        logic_flag <= 1'b1;
      end else if (status_read) begin
        logic_flag <= 1'b0;
      end
    end
  end

  // interrupt events
  always_comb begin
    event_set = '0;
    event_set[`EVT_RAIL_UV] = supply_in.rail_undervoltage && !rail_uv_last;
    event_set[`EVT_LOGIC_UV] = supply_in.logic_supply_undervoltage && !logic_uv_last;
    event_set[`EVT_RECOVER] = drivers_on && !drivers_last;
  end

  event_capture u_events (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_enable(clock_enable),
    .event_set(event_set),
    .event_clear(event_clear),
    .event_flag(event_flag)
  );

  // active-low host interrupt, immediate on rail undervoltage
  always_comb begin
    host_interrupt_n = !(
      (config_reg[`CFG_RAIL_IRQ_EN_BIT] && supply_in.rail_undervoltage)
      || (config_reg[`CFG_LOGIC_IRQ_EN_BIT] && supply_in.logic_supply_undervoltage)
      || |(event_flag & irq_mask));
  end

  // axi write channel capture
  always_comb begin
    s_axi_awready = !aw_held && !s_axi_bvalid;
    s_axi_wready = !w_held && !s_axi_bvalid;
    write_go = aw_held && w_held && !s_axi_bvalid;
    write_ok = (aw_addr == `CONFIG_ADDR) || (aw_addr == `IRQ_STATUS_ADDR)
      || (aw_addr == `IRQ_MASK_ADDR) || (aw_addr == `STATUS_ADDR);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 14'h0000;
    end else if (clock_enable) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (write_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (clock_enable) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (write_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else if (clock_enable) begin
      if (write_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= write_ok ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // configuration register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_reg <= `CFG_RESET;
    end else if (clock_enable && write_go && aw_addr == `CONFIG_ADDR) begin
      if (w_strb[0]) begin
        config_reg[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        config_reg[15:8] <= w_data[15:8];
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `MASK_RESET;
    end else if (clock_enable && write_go && aw_addr == `IRQ_MASK_ADDR && w_strb[0]) begin
      irq_mask <= w_data[`EVT_COUNT-1:0];
    end
  end

  // write one to clear
  always_comb begin
    event_clear = '0;
    if (write_go && aw_addr == `IRQ_STATUS_ADDR && w_strb[0]) begin
      event_clear = w_data[`EVT_COUNT-1:0];
    end
  end

  // read channel
  always_comb begin
    s_axi_arready = !s_axi_rvalid;
    read_go = s_axi_arvalid && s_axi_arready;
    status_read = read_go && s_axi_araddr == `STATUS_ADDR;
    next_rdata = 32'h00000000;
    next_rresp = 2'h0;
    unique case (s_axi_araddr)
      `CONFIG_ADDR: next_rdata[15:0] = config_reg;
      `STATUS_ADDR: begin
        next_rdata[`STS_RAIL_UV_BIT] = rail_flag;
        next_rdata[`STS_LOGIC_UV_BIT] = logic_flag;
        next_rdata[`STS_DRIVERS_OFF_BIT] = !drivers_on;
        next_rdata[`STS_REG_ON_BIT] = regulator_on;
        next_rdata[`STS_RAIL_NOW_BIT] = supply_in.rail_undervoltage;
      end
      `IRQ_STATUS_ADDR: next_rdata[`EVT_COUNT-1:0] = event_flag;
      `IRQ_MASK_ADDR: next_rdata[`EVT_COUNT-1:0] = irq_mask;
      default: next_rresp = 2'h2;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (clock_enable) begin
      if (read_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // predriver_supply_control

/* File: tb/predriver_supply_properties.sv */
// checker for the supply control block
// assumes it is bound to the top module and aclk is the only clock
module predriver_supply_checker
  import predriver_supply_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // supply side
  input wire supply_inputs_type supply_in,
  input wire supply_outputs_type supply_out,
  // write response
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  logic [8:0] low_count;
  // cycles since the rail comparator last showed undervoltage
  always_ff @(posedge aclk) begin
    if (!aresetn || supply_in.rail_undervoltage) low_count <= 9'h000;
    else if (low_count != 9'h12C) low_count <= low_count + 9'h001;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rail_uv_off: assert property (
    supply_in.rail_undervoltage |-> !supply_out.drivers_enable)
    else $error("drivers on during rail undervoltage");
  a_logic_uv_off: assert property (
    supply_in.logic_supply_undervoltage |-> !supply_out.drivers_enable)
    else $error("drivers on during logic undervoltage");
  a_filter_wait: assert property (
    supply_out.drivers_enable |-> low_count >= 9'h104)
    else $error("drivers back before filter time");
  a_filter_done: assert property (
    low_count == 9'h12C && !supply_in.rail_undervoltage && !supply_in.logic_supply_undervoltage
    |-> supply_out.drivers_enable)
    else $error("drivers not back after filter time");
  a_por_gate: assert property (
    !(supply_in.power_on_reset_n && supply_in.battery_lockout_clear)
    |-> !supply_out.regulator_enable)
    else $error("regulator on without power-on or battery");
  a_logic_missing: assert property (
    supply_in.logic_supply_undervoltage |-> !supply_out.regulator_enable)
    else $error("regulator on with logic supply low");
  a_pin_low_off: assert property (
    !supply_in.external_reset_pin_n |-> !supply_out.regulator_enable)
    else $error("regulator on with reset pin low");
  a_request_off: assert property (
    supply_out.regulator_off_request |-> !supply_out.regulator_enable)
    else $error("regulator on with off request");
  a_reset_default: assert property (
    $rose(aresetn) |-> supply_out.regulator_off_request)
    else $error("regulator not off by default after reset");
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  cover property (low_count == 9'h104);
  cover property (supply_out.regulator_off_request);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // predriver_supply_checker

bind predriver_supply_control predriver_supply_checker u_predriver_supply_checker (
  .aclk(aclk), .aresetn(aresetn), .supply_in(supply_in), .supply_out(supply_out),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp));

/* File: tb/host_irq_model.sv */
// host side model: counts interrupt requests on the line
// assumes an active-low level request sampled on aclk
module host_irq_model (
  // clock
  input wire logic aclk,
  // request line
  input wire logic host_interrupt_n,
  output int irq_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last_n = 1'b1;
  initial irq_count = 0;
  always @(posedge aclk) begin
    if (last_n && !host_interrupt_n) irq_count <= irq_count + 1;
    last_n <= host_interrupt_n;
  end
endmodule // host_irq_model

/* File: tb/predriver_supply_control_test.sv */
// self-checking bench for the supply control block
// assumes the package, register header, checker and host model are compiled first
`include "predriver_supply_regs.svh"
`define chk(n, e, s) begin tests_run++; if ((s) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module predriver_supply_control_test
  import predriver_supply_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk = 0, aresetn = 0;
  supply_inputs_type si = 5'b00111;
  supply_outputs_type so;
  logic irq_n, awready, wready, bvalid, arready, rvalid;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [13:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd;
  logic [3:0] wstrb = 0, v;
  logic [1:0] bresp, rresp, rr, br;
  int bad_count = 0, tests_run = 0, cycles = 0, irq_count, cfg = 0;
  logic luv_seen = 0;

  predriver_supply_control u_predriver_supply_control (.aclk(aclk), .aresetn(aresetn),
    .clock_enable(1'b1), .supply_in(si), .supply_out(so), .host_interrupt_n(irq_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  host_irq_model u_host_irq_model (.aclk(aclk), .host_interrupt_n(irq_n),
    .irq_count(irq_count));

  initial forever #2.5 aclk = ~aclk;

  task automatic print_verdict();
    if (bad_count == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
    while (pa || pw) begin
      @(posedge aclk);
      if (pa && awready) begin awvalid <= 0; pa = 0; end
      if (pw && wready) begin wvalid <= 0; pw = 0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    br = bresp;
    bready <= 0;
  endtask

  task automatic rdt(input logic [13:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata; rr = rresp; rready <= 0;
  endtask

  function automatic logic reg_exp();
    return si.power_on_reset_n & si.battery_lockout_clear & !si.logic_supply_undervoltage
      & si.external_reset_pin_n & !cfg[0];
  endfunction

  initial begin
    void'($urandom(80164));
    repeat (4) @(posedge aclk);
    `chk("reg_in_reset", 1'b0, so.regulator_enable)
    aresetn <= 1;
    cfg = 1;
    rdt(`CONFIG_ADDR);
    `chk("cfg_reset", 32'h1, rd)
    `chk("reg_default_off", 1'b0, so.regulator_enable)
    wr(`CONFIG_ADDR, 32'h0);
    cfg = 0;
    `chk("wr_okay", 2'b00, br)
    repeat (24) begin
      @(posedge aclk);
      v = 4'($urandom);
      si <= supply_inputs_type'({1'b0, v});
      luv_seen = luv_seen | v[3];
      @(negedge aclk);
      `chk("regulator", reg_exp(), so.regulator_enable)
      if (v[3]) `chk("drv_logic_uv", 1'b0, so.drivers_enable)
    end
    @(posedge aclk);
    si <= 5'b00111;
    repeat (270) @(posedge aclk);
    wr(`IRQ_STATUS_ADDR, 32'h7);
    wr(`IRQ_MASK_ADDR, 32'h7);
    wr(`CONFIG_ADDR, 32'h3);
    cfg = 3;
    @(negedge aclk);
    `chk("irq_idle", 1'b1, irq_n)
    `chk("off_request", 1'b1, so.regulator_off_request)
    `chk("reg_off", reg_exp(), so.regulator_enable)
    `chk("drv_up", 1'b1, so.drivers_enable)
    @(posedge aclk) si.rail_undervoltage <= 1;
    @(negedge aclk);
    `chk("drv_rail_uv", 1'b0, so.drivers_enable)
    `chk("irq_low", 1'b0, irq_n)
    @(posedge aclk) si.rail_undervoltage <= 0;
    repeat (100) @(posedge aclk);
    si.rail_undervoltage <= 1;
    @(posedge aclk) si.rail_undervoltage <= 0;
    repeat (258) @(posedge aclk);
    @(negedge aclk);
    `chk("drv_filter", 1'b0, so.drivers_enable)
    repeat (5) @(posedge aclk);
    @(negedge aclk);
    `chk("drv_back", 1'b1, so.drivers_enable)
    rdt(`STATUS_ADDR);
    `chk("status_1", {3'b000, luv_seen, 1'b1}, rd[4:0])
    rdt(`STATUS_ADDR);
    `chk("status_2", 5'h00, rd[4:0])
    wr(`IRQ_STATUS_ADDR, 32'h7);
    @(negedge aclk);
    `chk("irq_clear", 1'b1, irq_n)
    `chk("irq_count", 1, irq_count)
    wr(`IRQ_MASK_ADDR, 32'h0);
    wr(`CONFIG_ADDR, 32'h0);
    cfg = 0;
    @(posedge aclk) si.rail_undervoltage <= 1;
    @(negedge aclk);
    `chk("irq_masked", 1'b1, irq_n)
    `chk("reg_on", reg_exp(), so.regulator_enable)
    `chk("drv_int_uv", 1'b0, so.drivers_enable)
    wr(`CONFIG_ADDR, 32'h4);
    cfg = 4;
    @(posedge aclk) si.logic_supply_undervoltage <= 1;
    @(negedge aclk);
    `chk("irq_logic", 1'b0, irq_n)
    `chk("reg_logic_uv", reg_exp(), so.regulator_enable)
    rdt(14'h0010);
    `chk("unmapped", 2'b10, rr)
    wr(14'h0010, 32'h0);
    `chk("unmapped_wr", 2'b10, br)
    @(posedge aclk) aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(negedge aclk);
    `chk("off_after_reset", 1'b1, so.regulator_off_request)
    `chk("reg_after_reset", 1'b0, so.regulator_enable)
    print_verdict();
  end
endmodule // predriver_supply_control_test
